/* File: logic/deac_ctrl.sv */
`timescale 1ns/1ps
`include "deac_params.svh"
// Function
// - The display enable bit turns the whole LCD output on when 1 and off when 0.
// - A cleared display enable darkens every layer and the cursor whatever the attributes.
// - The display switch command loads its parameter byte as attributes and loads the enable from cmd_switch_on_i.
// - Bits 7-6 blank, show, or flash block 3 at frame rate /32 or /4.
// - Bits 5-4 blank, show, or flash block 2 at frame rate /32 or /4.
// - In dual-panel mode block 4 follows the block 2 field.
// - Bits 3-2 blank, show, or flash block 1 at frame rate /32 or /4.
// - Bits 1-0 blank, show, or flash the cursor at frame rate /32 or /64.
// - A flashing cursor is shown about 70 percent and hidden 30 percent of each period.
// - A memory write with the cursor blank turns it on steady and steps its position.
// - A memory read leaves a blank cursor blank but still steps its position.
// - Entering power save clears the display enable bit until software sets it again.
module deac_ctrl (
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  input  wire deac_pkg::deac_addr_t reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire deac_pkg::deac_byte_t reg_wdata_i,
  output      deac_pkg::deac_byte_t reg_rdata_o,
  input  wire logic                cmd_switch_i,
  input  wire logic                cmd_switch_on_i,
  input  wire deac_pkg::deac_byte_t cmd_param_i,
  input  wire logic                frame_start_i,
  input  wire logic                power_save_i,
  input  wire logic                dual_panel_i,
  input  wire logic                mem_wr_i,
  input  wire logic                mem_rd_i,
  output      logic                display_on_o,
  output      logic [3:0]          layer_vis_o,
  output      logic                cursor_vis_o,
  output      logic                cursor_enabled_o,
  output      logic                cursor_step_o
);
  import deac_pkg::*;

  deac_flash_if fl ();

  deac_flash_timer #(
    .CNT_W (`DEAC_FRAME_CNT_W)
  ) u_timer (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .fl        (fl)
  );

  assign fl.frame_tick = frame_start_i;

  logic       enable_q;
  logic       enable_d;
  deac_byte_t attr_q;
  deac_byte_t attr_d;
  deac_byte_t attr_sw;
  logic       ps_q;
  deac_byte_t rdata_q;
  logic       disp_q;
  logic [3:0] vis_q;
  logic       cur_vis_q;
  logic       cur_en_q;
  logic       step_q;

  wire        hit_on     = (reg_addr_i == `DEAC_ADDR_DISP_ON);
  wire        hit_attr   = (reg_addr_i == `DEAC_ADDR_ATTR);
  wire        ps_enter   = power_save_i & ~ps_q;
  wire        cur_blank  = (attr_sw[1:0] == `DEAC_ATTR_BLANK);
  wire        cur_wake   = mem_wr_i & cur_blank;

  // Command outranks a same-cycle register write: both carry the same bytes
  assign attr_sw = cmd_switch_i ? cmd_param_i
                 : (reg_wr_i & hit_attr) ? reg_wdata_i : attr_q;
  // Memory write wins over a clear of the cursor field
  assign attr_d  = cur_wake ? {attr_sw[7:2], `DEAC_ATTR_STEADY}
                 : attr_sw;

  // Power save entry wins over any set from software or command
  assign enable_d = ps_enter ? 1'b0
                  : cmd_switch_i ? cmd_switch_on_i
                  : (reg_wr_i & hit_on) ? reg_wdata_i[`DEAC_ENABLE_BIT]
                  : enable_q;

  wire deac_attr_t f3 = attr_q[`DEAC_BLK3_LSB +: 2];
  wire deac_attr_t f2 = attr_q[`DEAC_BLK2_LSB +: 2];
  wire deac_attr_t f1 = attr_q[`DEAC_BLK1_LSB +: 2];
  wire deac_attr_t fc = attr_q[`DEAC_CUR_LSB +: 2];

  wire show3 = deac_show(f3, fl.layer_slow_on, fl.layer_fast_on);
  wire show2 = deac_show(f2, fl.layer_slow_on, fl.layer_fast_on);
  wire show1 = deac_show(f1, fl.layer_slow_on, fl.layer_fast_on);
  wire show4 = dual_panel_i & show2;
  wire showc = deac_show(fc, fl.cur32_on, fl.cur64_on);

  wire [3:0] vis_d  = enable_q ? {show4, show3, show2, show1} : 4'h0;
  wire       curv_d = enable_q & showc;

  wire deac_byte_t rd_mux = hit_on   ? {7'h00, enable_q}
                          : hit_attr ? attr_q
                          : `DEAC_UNMAPPED_BYTE;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      enable_q <= 1'b0;
      attr_q   <= `DEAC_RST_BYTE;
      ps_q     <= 1'b0;
    end else begin
      enable_q <= enable_d;
      attr_q   <= attr_d;
      ps_q     <= power_save_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_q   <= `DEAC_RST_BYTE;
      disp_q    <= 1'b0;
      vis_q     <= 4'h0;
      cur_vis_q <= 1'b0;
      cur_en_q  <= 1'b0;
      step_q    <= 1'b0;
    end else begin
      rdata_q   <= reg_rd_i ? rd_mux : rdata_q;
      disp_q    <= enable_q;
      vis_q     <= vis_d;
      cur_vis_q <= curv_d;
      cur_en_q  <= (fc != `DEAC_ATTR_BLANK);
      step_q    <= mem_wr_i | mem_rd_i;
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign display_on_o     = disp_q;
  assign layer_vis_o      = vis_q;
  assign cursor_vis_o     = cur_vis_q;
  assign cursor_enabled_o = cur_en_q;
  assign cursor_step_o    = step_q;

  property p_enable_follows;
    @(posedge clock_i) disable iff (sys_rst_i)
    (reg_wr_i && hit_on && !cmd_switch_i && !ps_enter) |=> ##1
      display_on_o == $past(reg_wdata_i[0], 2);
  endproperty
  a_enable_follows: assert property (p_enable_follows)
    else $error("display output did not follow the enable write");

  property p_dark;
    @(posedge clock_i) disable iff (sys_rst_i)
    !enable_q |=> (layer_vis_o == 4'h0) && !cursor_vis_o && !display_on_o;
  endproperty
  a_dark: assert property (p_dark)
    else $error("output lit while display disabled");

  property p_cmd_load;
    @(posedge clock_i) disable iff (sys_rst_i)
    (cmd_switch_i && !mem_wr_i && !ps_enter) |=>
      attr_q == $past(cmd_param_i) && enable_q == $past(cmd_switch_on_i);
  endproperty
  a_cmd_load: assert property (p_cmd_load)
    else $error("display switch command did not load its parameters");

  property p_blk3_steady;
    @(posedge clock_i) disable iff (sys_rst_i)
    (enable_q && f3 == `DEAC_ATTR_STEADY) |=> layer_vis_o[2];
  endproperty
  a_blk3_steady: assert property (p_blk3_steady)
    else $error("block 3 not shown in steady mode");

  property p_blk2_blank;
    @(posedge clock_i) disable iff (sys_rst_i)
    (f2 == `DEAC_ATTR_BLANK) |=> !layer_vis_o[1];
  endproperty
  a_blk2_blank: assert property (p_blk2_blank)
    else $error("block 2 shown while blank");

  property p_blk4_share;
    @(posedge clock_i) disable iff (sys_rst_i)
    1'b1 |=> layer_vis_o[3] == ($past(dual_panel_i) && layer_vis_o[1]);
  endproperty
  a_blk4_share: assert property (p_blk4_share)
    else $error("block 4 does not track block 2 in dual-panel mode");

  property p_blk1_fast;
    @(posedge clock_i) disable iff (sys_rst_i)
    (enable_q && f1 == `DEAC_ATTR_FAST) |=> layer_vis_o[0] == $past(fl.layer_fast_on);
  endproperty
  a_blk1_fast: assert property (p_blk1_fast)
    else $error("block 1 fast flash phase wrong");

  property p_cur_rate;
    @(posedge clock_i) disable iff (sys_rst_i)
    (enable_q && fc[1]) |=>
      cursor_vis_o == ($past(fc[0]) ? $past(fl.cur64_on) : $past(fl.cur32_on));
  endproperty
  a_cur_rate: assert property (p_cur_rate)
    else $error("cursor flash rate selection wrong");

  property p_wr_wake;
    @(posedge clock_i) disable iff (sys_rst_i)
    cur_wake |=> attr_q[1:0] == `DEAC_ATTR_STEADY ##0 cursor_step_o ##1 cursor_enabled_o;
  endproperty
  a_wr_wake: assert property (p_wr_wake)
    else $error("memory write did not wake and step the cursor");

  property p_rd_step;
    @(posedge clock_i) disable iff (sys_rst_i)
    (mem_rd_i && !mem_wr_i && fc == `DEAC_ATTR_BLANK && !cmd_switch_i
     && !(reg_wr_i && hit_attr)) |=> cursor_step_o && fc == `DEAC_ATTR_BLANK;
  endproperty
  a_rd_step: assert property (p_rd_step)
    else $error("memory read woke the cursor or failed to step it");

  property p_ps_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
    ps_enter |=> !enable_q ##1 !display_on_o;
  endproperty
  a_ps_clear: assert property (p_ps_clear)
    else $error("power save entry left display enabled");

  property p_disp_copy;
    @(posedge clock_i) disable iff (sys_rst_i)
    1'b1 |=> display_on_o == $past(enable_q);
  endproperty
  a_disp_copy: assert property (p_disp_copy)
    else $error("display output does not copy the enable bit");

  property p_en_read;
    @(posedge clock_i) disable iff (sys_rst_i)
    (reg_rd_i && hit_on) |=> reg_rdata_o == {7'h00, $past(enable_q)};
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable register read back wrong");

  property p_blk3_slow;
    @(posedge clock_i) disable iff (sys_rst_i)
    (enable_q && f3 == `DEAC_ATTR_SLOW) |=> layer_vis_o[2] == $past(fl.layer_slow_on);
  endproperty
  a_blk3_slow: assert property (p_blk3_slow)
    else $error("block 3 slow flash phase wrong");

  property p_blk3_blank;
    @(posedge clock_i) disable iff (sys_rst_i)
    (f3 == `DEAC_ATTR_BLANK) |=> !layer_vis_o[2];
  endproperty
  a_blk3_blank: assert property (p_blk3_blank)
    else $error("block 3 shown while blank");

  property p_blk2_fast;
    @(posedge clock_i) disable iff (sys_rst_i)
    (enable_q && f2 == `DEAC_ATTR_FAST) |=> layer_vis_o[1] == $past(fl.layer_fast_on);
  endproperty
  a_blk2_fast: assert property (p_blk2_fast)
    else $error("block 2 fast flash phase wrong");

  property p_blk2_steady;
    @(posedge clock_i) disable iff (sys_rst_i)
    (enable_q && f2 == `DEAC_ATTR_STEADY) |=> layer_vis_o[1];
  endproperty
  a_blk2_steady: assert property (p_blk2_steady)
    else $error("block 2 not shown in steady mode");

  property p_blk1_slow;
    @(posedge clock_i) disable iff (sys_rst_i)
    (enable_q && f1 == `DEAC_ATTR_SLOW) |=> layer_vis_o[0] == $past(fl.layer_slow_on);
  endproperty
  a_blk1_slow: assert property (p_blk1_slow)
    else $error("block 1 slow flash phase wrong");

  property p_blk1_blank;
    @(posedge clock_i) disable iff (sys_rst_i)
    (f1 == `DEAC_ATTR_BLANK) |=> !layer_vis_o[0];
  endproperty
  a_blk1_blank: assert property (p_blk1_blank)
    else $error("block 1 shown while blank");

  property p_blk4_single;
    @(posedge clock_i) disable iff (sys_rst_i)
    !dual_panel_i |=> !layer_vis_o[3];
  endproperty
  a_blk4_single: assert property (p_blk4_single)
    else $error("block 4 shown outside dual-panel mode");

  property p_cur_steady;
    @(posedge clock_i) disable iff (sys_rst_i)
    (enable_q && fc == `DEAC_ATTR_STEADY) |=> cursor_vis_o;
  endproperty
  a_cur_steady: assert property (p_cur_steady)
    else $error("cursor not shown in steady mode");

  property p_cur_blank;
    @(posedge clock_i) disable iff (sys_rst_i)
    (fc == `DEAC_ATTR_BLANK) |=> !cursor_vis_o;
  endproperty
  a_cur_blank: assert property (p_cur_blank)
    else $error("cursor shown while blank");

  property p_cur_en_track;
    @(posedge clock_i) disable iff (sys_rst_i)
    1'b1 |=> cursor_enabled_o == ($past(fc) != `DEAC_ATTR_BLANK);
  endproperty
  a_cur_en_track: assert property (p_cur_en_track)
    else $error("cursor enabled flag does not follow the cursor field");

  property p_step_idle;
    @(posedge clock_i) disable iff (sys_rst_i)
    (!mem_wr_i && !mem_rd_i) |=> !cursor_step_o;
  endproperty
  a_step_idle: assert property (p_step_idle)
    else $error("cursor stepped without a memory access");

  c_fast_flash: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    enable_q && f1 == `DEAC_ATTR_FAST ##1 layer_vis_o[0] ##[1:8] !layer_vis_o[0]);
  c_wake: cover property (@(posedge clock_i) disable iff (sys_rst_i) cur_wake);
  c_ps: cover property (@(posedge clock_i) disable iff (sys_rst_i) enable_q && ps_enter);
  c_dual: cover property (@(posedge clock_i) disable iff (sys_rst_i) layer_vis_o[3]);
endmodule

/* File: logic/deac_params.svh */
`ifndef DEAC_PARAMS_SVH
`define DEAC_PARAMS_SVH

`define DEAC_ADDR_W          16
`define DEAC_ADDR_DISP_ON    16'h8009
`define DEAC_ADDR_ATTR       16'h800A
`define DEAC_RST_BYTE        8'h00
`define DEAC_UNMAPPED_BYTE   8'h00

`define DEAC_ENABLE_BIT      0
`define DEAC_BLK3_LSB        6
`define DEAC_BLK2_LSB        4
`define DEAC_BLK1_LSB        2
`define DEAC_CUR_LSB         0

`define DEAC_ATTR_BLANK      2'h0
`define DEAC_ATTR_STEADY     2'h1
`define DEAC_ATTR_SLOW       2'h2
`define DEAC_ATTR_FAST       2'h3

`define DEAC_FRAME_CNT_W     6
`define DEAC_LAYER_SLOW_BIT  4
`define DEAC_LAYER_FAST_BIT  1
`define DEAC_CUR32_ON_FRAMES 5'h16
`define DEAC_CUR64_ON_FRAMES 6'h2D

`endif

/* File: logic/deac_pkg.sv */
package deac_pkg;
  typedef logic [7:0]  deac_byte_t;
  typedef logic [15:0] deac_addr_t;
  typedef logic [1:0]  deac_attr_t;

  // Blank, steady or one of two flash phases
  function automatic logic deac_show(input deac_attr_t attr,
                                     input logic       slow_on,
                                     input logic       fast_on);
    logic show;
    show = 1'b0;
    case (attr)
      2'h0:    show = 1'b0;
      2'h1:    show = 1'b1;
      2'h2:    show = slow_on;
      2'h3:    show = fast_on;
      default: show = 1'b0;
    endcase
    return show;
  endfunction
endpackage

/* File: logic/deac_flash_if.sv */
`timescale 1ns/1ps
interface deac_flash_if;
  logic frame_tick;
  logic layer_slow_on;
  logic layer_fast_on;
  logic cur32_on;
  logic cur64_on;

  modport timer (input frame_tick, output layer_slow_on, output layer_fast_on,
                 output cur32_on, output cur64_on);
  modport ctrl  (output frame_tick, input layer_slow_on, input layer_fast_on,
                 input cur32_on, input cur64_on);
endinterface

/* File: logic/deac_flash_timer.sv */
`timescale 1ns/1ps
`include "deac_params.svh"
module deac_flash_timer #(
  parameter int CNT_W = `DEAC_FRAME_CNT_W
) (
  input  wire logic   clock_i,
  input  wire logic   sys_rst_i,
  deac_flash_if.timer fl
);
  import deac_pkg::*;

  // Narrower counters cannot hold the 64-frame cursor period
  if (CNT_W < `DEAC_FRAME_CNT_W) begin : g_cnt_w_check
    $error("deac_flash_timer: CNT_W too small for a 64-frame period");
  end

  // One counter for all layers keeps their flashes in phase
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  assign cnt_d = fl.frame_tick ? cnt_q + 1'b1 : cnt_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Half-period low, half high: 50% layer flash
  assign fl.layer_slow_on = ~cnt_q[`DEAC_LAYER_SLOW_BIT];
  assign fl.layer_fast_on = ~cnt_q[`DEAC_LAYER_FAST_BIT];
  // 22 of 32 and 45 of 64 frames are the closest whole-frame fit to 70%
  assign fl.cur32_on = (cnt_q[4:0] < `DEAC_CUR32_ON_FRAMES);
  assign fl.cur64_on = (cnt_q[5:0] < `DEAC_CUR64_ON_FRAMES);

  property p_count_step;
    @(posedge clock_i) disable iff (sys_rst_i)
    fl.frame_tick |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("frame counter did not advance on frame start");

  property p_cur32_off;
    @(posedge clock_i) disable iff (sys_rst_i)
    (fl.frame_tick && cnt_q[4:0] == 5'h15) |=> !fl.cur32_on && $past(fl.cur32_on);
  endproperty
  a_cur32_off: assert property (p_cur32_off)
    else $error("cursor slow flash not off after 22 frames");

  property p_cur64_on;
    @(posedge clock_i) disable iff (sys_rst_i)
    (fl.frame_tick && cnt_q[5:0] == 6'h2B) |=> fl.cur64_on ##0 $past(fl.cur64_on);
  endproperty
  a_cur64_on: assert property (p_cur64_on)
    else $error("cursor 64-frame flash off too early");

  property p_layer_duty;
    @(posedge clock_i) disable iff (sys_rst_i)
    (fl.frame_tick && cnt_q[3:0] == 4'hF) |=> fl.layer_slow_on != $past(fl.layer_slow_on);
  endproperty
  a_layer_duty: assert property (p_layer_duty)
    else $error("slow layer phase did not flip after 16 frames");
endmodule

/* File: sim/deac_panel_model.sv */
`timescale 1ns/1ps
module deac_panel_model #(
  parameter int FRAME_LEN = 8
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clear_i,
  input  wire logic       display_on_i,
  input  wire logic [3:0] layer_vis_i,
  input  wire logic       cursor_vis_i,
  output      logic       frame_start_o,
  output      int         shown_o [5],
  output      int         toggles_o [5]
);
  int         tick_q;
  logic [4:0] prev_q;
  logic [4:0] lit;

  // A dark panel lights nothing, whatever the layer lines say
  assign lit = {cursor_vis_i, layer_vis_i} & {5{display_on_i}};

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tick_q        <= 0;
      frame_start_o <= 1'b0;
    end else begin
      tick_q        <= (tick_q == FRAME_LEN - 1) ? 0 : tick_q + 1;
      frame_start_o <= (tick_q == FRAME_LEN - 1);
    end
  end

  // One scan per frame; clear restarts counts but keeps the last sample
  always_ff @(posedge clock_i) begin
    if (frame_start_o) begin
      prev_q <= lit;
    end
    for (int i = 0; i < 5; i++) begin
      if (clear_i) begin
        shown_o[i]   <= 0;
        toggles_o[i] <= 0;
      end else if (frame_start_o) begin
        shown_o[i]   <= shown_o[i] + int'(lit[i]);
        toggles_o[i] <= toggles_o[i] + int'(lit[i] != prev_q[i]);
      end
    end
  end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "deac_params.svh"
module tb_top;
  import deac_pkg::*;
  localparam int LIMIT = 10000;
  logic clock_i, sys_rst_i, reg_wr_i, reg_rd_i, cmd_switch_i, cmd_switch_on_i;
  logic frame_start_i, power_save_i, dual_panel_i, mem_wr_i, mem_rd_i, clear;
  deac_addr_t reg_addr_i;
  deac_byte_t reg_wdata_i, reg_rdata_o, cmd_param_i;
  logic display_on_o, cursor_vis_o, cursor_enabled_o, cursor_step_o;
  logic [3:0] layer_vis_o;
  logic [7:0] vis_w, cur_w;
  int shown [5];
  int toggles [5];
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int exp_lay [4] = '{0, 64, 32, 32};
  int exp_cur [4] = '{0, 64, 44, 45};
  int tog_lay [4] = '{0, 0, 4, 32};
  int tog_cur [4] = '{0, 0, 4, 2};

  assign vis_w = {display_on_o, cursor_vis_o, 2'h0, layer_vis_o};
  assign cur_w = {6'h00, cursor_enabled_o, cursor_step_o};

  deac_ctrl u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .cmd_switch_i(cmd_switch_i),
    .cmd_switch_on_i(cmd_switch_on_i), .cmd_param_i(cmd_param_i),
    .frame_start_i(frame_start_i), .power_save_i(power_save_i),
    .dual_panel_i(dual_panel_i), .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i),
    .display_on_o(display_on_o), .layer_vis_o(layer_vis_o), .cursor_vis_o(cursor_vis_o),
    .cursor_enabled_o(cursor_enabled_o), .cursor_step_o(cursor_step_o));

  deac_panel_model u_panel (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clear_i(clear),
    .display_on_i(display_on_o), .layer_vis_i(layer_vis_o), .cursor_vis_i(cursor_vis_o),
    .frame_start_o(frame_start_i), .shown_o(shown), .toggles_o(toggles));

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected at %0t: frame count %0d, wanted %0d", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic reg_write(input deac_addr_t a, input deac_byte_t d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input deac_addr_t a, input deac_byte_t exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_val(reg_rdata_o, exp);
  endtask

  task automatic switch_cmd(input logic on, input deac_byte_t p);
    @(posedge clock_i);
    cmd_switch_on_i <= on;
    cmd_param_i     <= p;
    cmd_switch_i    <= 1'b1;
    @(posedge clock_i);
    cmd_switch_i <= 1'b0;
  endtask

  // Ends just after the taking edge, when the step pulse is showing
  task automatic mem_access(input logic wr);
    @(posedge clock_i);
    mem_wr_i <= wr;
    mem_rd_i <= !wr;
    @(posedge clock_i);
    mem_wr_i <= 1'b0;
    mem_rd_i <= 1'b0;
    #1;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    {sys_rst_i, reg_wr_i, reg_rd_i, cmd_switch_i, cmd_switch_on_i} = 5'b10000;
    {power_save_i, dual_panel_i, mem_wr_i, mem_rd_i, clear} = 5'b00000;
    reg_addr_i = 16'h0000;
    reg_wdata_i = 8'h00;
    cmd_param_i = 8'h00;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    reg_read(`DEAC_ADDR_DISP_ON, `DEAC_RST_BYTE);
    reg_read(`DEAC_ADDR_ATTR, `DEAC_RST_BYTE);
    reg_write(16'h8000, 8'hFF);
    reg_read(16'h8000, `DEAC_UNMAPPED_BYTE);
    reg_write(`DEAC_ADDR_ATTR, 8'h55);
    reg_write(`DEAC_ADDR_DISP_ON, 8'hFE);
    wait_cyc(2);
    chk_val(vis_w, 8'h00);
    reg_write(`DEAC_ADDR_DISP_ON, 8'hFF);
    reg_read(`DEAC_ADDR_DISP_ON, 8'h01);
    wait_cyc(2);
    chk_val(vis_w, 8'hC7);
    dual_panel_i <= 1'b1;
    wait_cyc(3);
    chk_val(vis_w, 8'hCF);
    for (int c = 0; c < 4; c++) begin
      reg_write(`DEAC_ADDR_ATTR, {4{c[1:0]}});
      wait_cyc(20);
      clear <= 1'b1;
      @(posedge clock_i);
      clear <= 1'b0;
      wait_cyc(512);
      for (int i = 0; i < 4; i++) begin
        chk_cnt(shown[i], exp_lay[c]);
        chk_cnt(toggles[i], tog_lay[c]);
      end
      chk_cnt(shown[4], exp_cur[c]);
      chk_cnt(toggles[4], tog_cur[c]);
    end
    switch_cmd(1'b0, 8'hE4);
    reg_read(`DEAC_ADDR_ATTR, 8'hE4);
    reg_read(`DEAC_ADDR_DISP_ON, 8'h00);
    switch_cmd(1'b1, 8'h1B);
    wait_cyc(2);
    chk_val({7'h00, display_on_o}, 8'h01);
    reg_write(`DEAC_ADDR_ATTR, 8'h54);
    mem_access(1'b0);
    chk_val(cur_w, 8'h01);
    wait_cyc(2);
    chk_val(cur_w, 8'h00);
    reg_read(`DEAC_ADDR_ATTR, 8'h54);
    mem_access(1'b1);
    chk_val(cur_w, 8'h01);
    wait_cyc(2);
    chk_val(cur_w, 8'h02);
    reg_read(`DEAC_ADDR_ATTR, 8'h55);
    power_save_i <= 1'b1;
    wait_cyc(3);
    chk_val({7'h00, display_on_o}, 8'h00);
    reg_read(`DEAC_ADDR_DISP_ON, 8'h00);
    power_save_i <= 1'b0;
    wait_cyc(3);
    chk_val({7'h00, display_on_o}, 8'h00);
    reg_write(`DEAC_ADDR_DISP_ON, 8'h01);
    wait_cyc(2);
    chk_val({7'h00, display_on_o}, 8'h01);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    wait_cyc(1);
    chk_val(vis_w, 8'h00);
    reg_read(`DEAC_ADDR_DISP_ON, `DEAC_RST_BYTE);
    reg_read(`DEAC_ADDR_ATTR, `DEAC_RST_BYTE);
    final_report();
  end
endmodule
